// ===== rtl/phyr_pkg.sv
// Constants, field positions and carrier types for the PHY advertisement and special control register bank.
// Assumes a 32-bit Avalon-MM slave port with byte addresses; every register sits in one aligned word.
package phyr_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [9:0] IDX_ID_LOW = 10'h05C;
    localparam logic [9:0] IDX_ID_HIGH = 10'h05E;
    localparam logic [9:0] IDX_ADVERTISE = 10'h060;
    localparam logic [9:0] IDX_PARTNER = 10'h062;
    localparam logic [9:0] IDX_SPEC1 = 10'h066;
    localparam logic [9:0] IDX_SPEC2 = 10'h06A;
    // Alias windows onto the shared storage
    localparam logic [9:0] IDX_CTRL4 = 10'h0F0;
    localparam logic [9:0] IDX_DIAG1 = 10'h0F2;
    localparam logic [9:0] IDX_DIAG2 = 10'h0F4;

    // Advertisement and partner ability fields
    localparam int ADV_PAUSE_BIT = 10;
    localparam int ADV_RSVD9_BIT = 9;
    localparam int ADV_ABIL_LSB = 5;
    localparam logic [4:0] SELECTOR_VAL = 5'h01;
    localparam int CTRL4_PAUSE_BIT = 4;
    localparam int CTRL4_ABIL_LSB = 0;

    // Special control and status fields
    localparam int SPEC_POL_BIT = 5;
    localparam int SPEC_MDIX_BIT = 4;
    localparam int SPEC_FORCE_BIT = 3;
    localparam int SPEC_EEE_BIT = 2;
    localparam int SPEC_LOOP_BIT = 1;
    localparam int SPEC_RSVD0_BIT = 0;
    localparam int DIAG_FORCE_BIT = 11;
    localparam int DIAG_LOOP_BIT = 9;

    // Reset values
    localparam logic ADV_PAUSE_RST = 1'b1;
    localparam logic [3:0] ADV_ABIL_RST = 4'hF;
    localparam logic ADV_RSVD9_RST = 1'b0;
    localparam logic FORCE_RST = 1'b0;
    localparam logic EEE_DIS_RST = 1'b1;
    localparam logic LOOP_RST = 1'b0;
    localparam logic RSVD0_RST = 1'b0;

    localparam int NUM_PORTS = 2;

    // Ability order: 100 full, 100 half, 10 full, 10 half (msb first)
    typedef struct packed {
        logic pause;
        logic [3:0] ability;
    } phyr_ability_t;

    typedef struct packed {
        logic polarity_rev;
        logic mdix;
    } phyr_line_stat_t;

endpackage

// ===== rtl/phyr_regs.sv
// Register bank: port 2 PHY identifier, advertisement, partner ability and both special control registers.
// Assumes an Avalon-MM master on the same clock and PHY status inputs generated on that clock.
//
// Summary of operation
// - Identifier words are fixed, writes ignored
// - Advertised pause bit, resets set, shared with ctrl4
// - Four ability advertisement bits, reset set, shared
// - Next page, remote fault read zero; reserved bit 9 stored, reads back
// - Partner pause bit mirrors status input
// - Partner ability bits mirror status inputs
// - Partner upper bits zero, low field 0x01
// - Special bit 5 shows polarity reversal
// - Special bit 4 shows MDI-X state
// - Special bit 3 forces link pass
// - Special bit 2 disables 10BASE-Te, resets set
// - Port 1 bit 1 enables near-end loopback
// - Port 2 bit 1 enables near-end loopback
`timescale 1ns/1ns
module phyr_regs
    import phyr_pkg::*;
#(
    parameter logic [15:0] PHY_ID_LOW = 16'h5A3C, // Arbitrary value
    parameter logic [15:0] PHY_ID_HIGH = 16'h0C3A // Arbitrary value
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Avalon-MM slave
    input wire logic [11:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // PHY status
    input wire phyr_line_stat_t i_port1_line,
    input wire phyr_line_stat_t i_port2_line,
    input wire phyr_ability_t i_port2_partner,
    // PHY control
    output phyr_ability_t o_port2_advertise,
    output logic [NUM_PORTS-1:0] o_force_link,
    output logic [NUM_PORTS-1:0] o_eee10_disable,
    output logic [NUM_PORTS-1:0] o_near_loopback
);

    logic wait_reg;
    logic [31:0] rdata_reg;
    phyr_ability_t adv_reg;
    logic adv_rsvd9_reg;
    logic [9:0] idx;
    logic req;
    logic wr_go;
    logic wr_lo;
    logic wr_hi;
    logic [15:0] rd_next;
    logic [NUM_PORTS-1:0] spec_wr;
    logic [NUM_PORTS-1:0] diag_wr;
    logic [NUM_PORTS-1:0] rsvd0;
    phyr_line_stat_t line_stat [NUM_PORTS];

    assign idx = i_avs_address[11:2];
    assign req = i_avs_read | i_avs_write;
    // A write lands on the edge where the master sees waitrequest low
    assign wr_go = i_avs_write & ~wait_reg;
    assign wr_lo = wr_go & i_avs_byteenable[0];
    assign wr_hi = wr_go & i_avs_byteenable[1];
    assign line_stat[0] = i_port1_line;
    assign line_stat[1] = i_port2_line;

    // Two-cycle answer: first edge takes the request and latches read data, second completes it
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wait_reg <= 1'b1;
        end else if (req && wait_reg) begin
            wait_reg <= 1'b0;
        end else begin
            wait_reg <= 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else if (i_avs_read && wait_reg) begin
            rdata_reg <= {16'h0000, rd_next};
        end
    end

    assign o_avs_waitrequest = wait_reg;
    assign o_avs_readdata = rdata_reg;

    // Advertisement storage, reachable from its own word and from the ctrl4 alias
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            adv_reg.pause <= ADV_PAUSE_RST;
            adv_reg.ability <= ADV_ABIL_RST;
        end else if (idx == IDX_ADVERTISE) begin
            if (wr_hi) begin
                adv_reg.pause <= i_avs_writedata[ADV_PAUSE_BIT];
                adv_reg.ability[3] <= i_avs_writedata[ADV_ABIL_LSB+3];
            end
            if (wr_lo) begin
                adv_reg.ability[2:0] <= i_avs_writedata[ADV_ABIL_LSB+2:ADV_ABIL_LSB];
            end
        end else if (idx == IDX_CTRL4 && wr_lo) begin
            adv_reg.pause <= i_avs_writedata[CTRL4_PAUSE_BIT];
            adv_reg.ability <= i_avs_writedata[CTRL4_ABIL_LSB+3:CTRL4_ABIL_LSB];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            adv_rsvd9_reg <= ADV_RSVD9_RST;
        end else if (idx == IDX_ADVERTISE && wr_hi) begin
            adv_rsvd9_reg <= i_avs_writedata[ADV_RSVD9_BIT];
        end
    end

    assign o_port2_advertise = adv_reg;

    generate
        for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
            localparam logic [9:0] SPEC_IDX = (p == 0) ? IDX_SPEC1 : IDX_SPEC2;
            localparam logic [9:0] DIAG_IDX = (p == 0) ? IDX_DIAG1 : IDX_DIAG2;
            assign spec_wr[p] = wr_lo && idx == SPEC_IDX;
            assign diag_wr[p] = wr_hi && idx == DIAG_IDX;
            phyr_spec_ctrl u_spec (
                .i_sys_clk(i_sys_clk),
                .i_rst_n(i_rst_n),
                .i_spec_wr(spec_wr[p]),
                .i_diag_wr(diag_wr[p]),
                .i_wdata(i_avs_writedata[15:0]),
                .o_force_link(o_force_link[p]),
                .o_eee10_disable(o_eee10_disable[p]),
                .o_near_loopback(o_near_loopback[p]),
                .o_rsvd0(rsvd0[p])
            );
        end
    endgenerate

    // Unsupported fields are hardwired; reserved advertisement bit 9 and special bit 0 are stored and read back
    always_comb begin
        rd_next = 16'h0000;
        case (idx)
            IDX_ID_LOW: rd_next = PHY_ID_LOW;
            IDX_ID_HIGH: rd_next = PHY_ID_HIGH;
            IDX_ADVERTISE: rd_next = {5'h00, adv_reg.pause, adv_rsvd9_reg, adv_reg.ability, SELECTOR_VAL};
            IDX_PARTNER: rd_next = {5'h00, i_port2_partner.pause, 1'b0, i_port2_partner.ability, SELECTOR_VAL};
            IDX_SPEC1: rd_next = {10'h000, line_stat[0], o_force_link[0], o_eee10_disable[0],
                                  o_near_loopback[0], rsvd0[0]};
            IDX_SPEC2: rd_next = {10'h000, line_stat[1], o_force_link[1], o_eee10_disable[1],
                                  o_near_loopback[1], rsvd0[1]};
            IDX_CTRL4: rd_next = {11'h000, adv_reg};
            IDX_DIAG1: rd_next = {4'h0, o_force_link[0], 1'b0, o_near_loopback[0], 9'h000};
            IDX_DIAG2: rd_next = {4'h0, o_force_link[1], 1'b0, o_near_loopback[1], 9'h000};
            default: rd_next = 16'h0000;
        endcase
    end

    // Checks
    sequence s_take_read(logic [9:0] i);
        i_avs_read && wait_reg && idx == i;
    endsequence

    sequence s_write_lo(logic [9:0] i);
        wr_lo && idx == i;
    endsequence

    sequence s_write_hi(logic [9:0] i);
        wr_hi && idx == i;
    endsequence

    a_id_low_fixed: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_take_read(IDX_ID_LOW) |=> o_avs_readdata == {16'h0000, PHY_ID_LOW} && !o_avs_waitrequest)
        else $error("Identifier low word read wrong");

    a_ctrl4_pause_alias: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_write_lo(IDX_CTRL4) |=> o_port2_advertise.pause == $past(i_avs_writedata[CTRL4_PAUSE_BIT]))
        else $error("Pause alias write not stored");

    a_adv_ability_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_write_lo(IDX_ADVERTISE) |=> o_port2_advertise.ability[2:0] == $past(i_avs_writedata[7:5]))
        else $error("Advertised ability write not stored");

    a_adv_fixed_bits: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_take_read(IDX_ADVERTISE) |=> o_avs_readdata[15:11] == 5'h00 && o_avs_readdata[4:0] == SELECTOR_VAL)
        else $error("Advertisement fixed bits wrong");

    a_partner_mirror: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_take_read(IDX_PARTNER) |=> o_avs_readdata[10:5] == {$past(i_port2_partner.pause), 1'b0,
                                                             $past(i_port2_partner.ability)})
        else $error("Partner ability mirror wrong");

    a_partner_fixed: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_take_read(IDX_PARTNER) |=> o_avs_readdata[15:13] == 3'h0 && o_avs_readdata[4:0] == 5'h01)
        else $error("Partner fixed bits wrong");

    a_spec2_status: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_take_read(IDX_SPEC2) |=> o_avs_readdata[5:4] == $past(i_port2_line))
        else $error("Port 2 line status mirror wrong");

    a_diag_force_alias: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        wr_hi && idx == IDX_DIAG1 |=> o_force_link[0] == $past(i_avs_writedata[DIAG_FORCE_BIT]))
        else $error("Force link alias not stored");

    a_eee_disable_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_write_lo(IDX_SPEC2) |=> o_eee10_disable[1] == $past(i_avs_writedata[SPEC_EEE_BIT]))
        else $error("Energy saving disable not stored");

    a_loop1_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_write_lo(IDX_SPEC1) |=> o_near_loopback[0] == $past(i_avs_writedata[SPEC_LOOP_BIT])
                                  && o_near_loopback[1] == $past(o_near_loopback[1]))
        else $error("Port 1 loopback write wrong");

    a_loop2_alias_read: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_take_read(IDX_DIAG2) |=> o_avs_readdata[DIAG_LOOP_BIT] == o_near_loopback[1])
        else $error("Port 2 loopback alias read wrong");

    a_ctrl4_read_alias: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_take_read(IDX_CTRL4) |=> o_avs_readdata[4:0] == o_port2_advertise)
        else $error("Control 4 alias read wrong");

    // Bus handshake: exactly one wait cycle, then one cycle of completion
    a_wait_answer: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        req && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("Request not answered after one wait cycle");

    a_wait_single_low: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("Waitrequest low for more than one cycle");

    a_id_high_fixed: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_take_read(IDX_ID_HIGH) |=> o_avs_readdata == {16'h0000, PHY_ID_HIGH})
        else $error("Identifier high word read wrong");

    a_adv_pause_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_write_hi(IDX_ADVERTISE) |=> o_port2_advertise.pause == $past(i_avs_writedata[ADV_PAUSE_BIT]))
        else $error("Advertised pause write not stored");

    a_adv_ability_hi: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_write_hi(IDX_ADVERTISE) |=> o_port2_advertise.ability[3] == $past(i_avs_writedata[ADV_ABIL_LSB+3]))
        else $error("Advertised 100 full write not stored");

    // A write through the upper lane alone must not disturb the lower ability bits
    a_adv_lane_guard: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        wr_hi && !wr_lo && idx == IDX_ADVERTISE |=> o_port2_advertise.ability[2:0] == $past(adv_reg.ability[2:0]))
        else $error("Advertised ability changed by other lane");

    a_ctrl4_ability_alias: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_write_lo(IDX_CTRL4) |=> o_port2_advertise.ability == $past(i_avs_writedata[3:0]))
        else $error("Ability alias write not stored");

    a_adv_read_fields: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_take_read(IDX_ADVERTISE) |=> o_avs_readdata[10] == $past(adv_reg.pause)
                                       && o_avs_readdata[8:5] == $past(adv_reg.ability))
        else $error("Advertisement read fields wrong");

    a_partner_pause: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_take_read(IDX_PARTNER) |=> o_avs_readdata[10] == $past(i_port2_partner.pause))
        else $error("Partner pause mirror wrong");

    a_partner_ack_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_take_read(IDX_PARTNER) |=> o_avs_readdata[14] == 1'b0 && o_avs_readdata[9] == 1'b0)
        else $error("Partner acknowledge or reserved bit set");

    a_spec1_polarity: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_take_read(IDX_SPEC1) |=> o_avs_readdata[SPEC_POL_BIT] == $past(i_port1_line.polarity_rev))
        else $error("Port 1 polarity mirror wrong");

    a_spec1_mdix: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_take_read(IDX_SPEC1) |=> o_avs_readdata[SPEC_MDIX_BIT] == $past(i_port1_line.mdix))
        else $error("Port 1 crossover mirror wrong");

    a_spec2_mdix: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_take_read(IDX_SPEC2) |=> o_avs_readdata[SPEC_MDIX_BIT] == $past(i_port2_line.mdix))
        else $error("Port 2 crossover mirror wrong");

    a_spec1_force_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_write_lo(IDX_SPEC1) |=> o_force_link[0] == $past(i_avs_writedata[SPEC_FORCE_BIT]))
        else $error("Port 1 force link write not stored");

    a_spec2_force_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_write_lo(IDX_SPEC2) |=> o_force_link[1] == $past(i_avs_writedata[SPEC_FORCE_BIT]))
        else $error("Port 2 force link write not stored");

    a_diag2_force_alias: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_write_hi(IDX_DIAG2) |=> o_force_link[1] == $past(i_avs_writedata[DIAG_FORCE_BIT]))
        else $error("Port 2 force link alias not stored");

    a_eee1_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_write_lo(IDX_SPEC1) |=> o_eee10_disable[0] == $past(i_avs_writedata[SPEC_EEE_BIT]))
        else $error("Port 1 energy saving disable not stored");

    // The energy saving bit has no alias, so the diagnostic window must leave it alone
    a_eee_diag_keep: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_write_hi(IDX_DIAG1) |=> o_eee10_disable == $past(o_eee10_disable))
        else $error("Energy saving disable changed by alias write");

    a_loop1_diag_alias: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_write_hi(IDX_DIAG1) |=> o_near_loopback[0] == $past(i_avs_writedata[DIAG_LOOP_BIT]))
        else $error("Port 1 loopback alias not stored");

    a_loop2_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_write_lo(IDX_SPEC2) |=> o_near_loopback[1] == $past(i_avs_writedata[SPEC_LOOP_BIT])
                                  && o_near_loopback[0] == $past(o_near_loopback[0]))
        else $error("Port 2 loopback write wrong");

    a_loop2_diag_alias: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_write_hi(IDX_DIAG2) |=> o_near_loopback[1] == $past(i_avs_writedata[DIAG_LOOP_BIT]))
        else $error("Port 2 loopback alias not stored");

    a_spec1_read_alias: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_take_read(IDX_SPEC1) |=> o_avs_readdata[3:1] == {$past(o_force_link[0]), $past(o_eee10_disable[0]),
                                                          $past(o_near_loopback[0])})
        else $error("Port 1 special control read wrong");

    a_diag1_read_alias: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_take_read(IDX_DIAG1) |=> o_avs_readdata[DIAG_FORCE_BIT] == $past(o_force_link[0])
                                   && o_avs_readdata[DIAG_LOOP_BIT] == $past(o_near_loopback[0]))
        else $error("Port 1 diagnostic alias read wrong");

endmodule

// ===== rtl/phyr_spec_ctrl.sv
// Per-port storage of the special control bits shared with the link-diagnostic register.
// Assumes the two write strobes are never high together; each comes from a different address.
`timescale 1ns/1ns
module phyr_spec_ctrl
    import phyr_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Write strobes and data
    input wire logic i_spec_wr,
    input wire logic i_diag_wr,
    input wire logic [15:0] i_wdata,
    // Stored bits
    output logic o_force_link,
    output logic o_eee10_disable,
    output logic o_near_loopback,
    output logic o_rsvd0
);

    // One flop per bit serves both locations, so neither view can go stale
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_force_link <= FORCE_RST;
            o_near_loopback <= LOOP_RST;
        end else if (i_spec_wr) begin
            o_force_link <= i_wdata[SPEC_FORCE_BIT];
            o_near_loopback <= i_wdata[SPEC_LOOP_BIT];
        end else if (i_diag_wr) begin
            o_force_link <= i_wdata[DIAG_FORCE_BIT];
            o_near_loopback <= i_wdata[DIAG_LOOP_BIT];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_eee10_disable <= EEE_DIS_RST;
            o_rsvd0 <= RSVD0_RST;
        end else if (i_spec_wr) begin
            o_eee10_disable <= i_wdata[SPEC_EEE_BIT];
            o_rsvd0 <= i_wdata[SPEC_RSVD0_BIT];
        end
    end

endmodule

// ===== testbench/phyr_phy_model.sv
// Behavioural far side: line polarity, crossover state and the partner's base page.
// Assumes the bench loads a new line state now and then; values change only on the system clock.
`timescale 1ns/1ns
module phyr_phy_model
    import phyr_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // New line state from the bench
    input wire logic i_load,
    input wire logic [8:0] i_state,
    // Line status toward the register bank
    output phyr_line_stat_t o_port1_line,
    output phyr_line_stat_t o_port2_line,
    output phyr_ability_t o_port2_partner
);
    logic [8:0] state_reg;

    // No link partner seen until the bench says otherwise
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= 9'h000;
        end else if (i_load) begin
            state_reg <= i_state;
        end
    end

    assign o_port1_line = phyr_line_stat_t'(state_reg[8:7]);
    assign o_port2_line = phyr_line_stat_t'(state_reg[6:5]);
    assign o_port2_partner = phyr_ability_t'(state_reg[4:0]);
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the PHY register bank: random bus traffic against a shadow of the registers.
// Assumes a single 25 MHz clock and an Avalon-MM slave that answers after one wait cycle.
`timescale 1ns/1ns
`define CHECK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin miscompares++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module testbench;
    import phyr_pkg::*;
    localparam logic [15:0] ID_LO = 16'h3D71; // Arbitrary value
    localparam logic [15:0] ID_HI = 16'h0A5E; // Arbitrary value
    logic i_sys_clk = 1'b0, i_rst_n = 1'b0, rd = 1'b0, wr = 1'b0, st_load = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000, rdata, seed = 32'hB66A, q;
    logic [3:0] be = 4'h0, ab;
    logic [8:0] st_val = 9'h000, st;
    logic waitreq, pause, r9;
    logic [1:0] f, e, l, r0, o_force, o_eee, o_loop;
    phyr_line_stat_t port1_line, port2_line;
    phyr_ability_t partner, o_adv;
    int miscompares = 0, tests_run = 0;
    logic [9:0] idx_tab [10] = '{IDX_ID_LOW, IDX_ID_HIGH, IDX_ADVERTISE, IDX_PARTNER, IDX_SPEC1, IDX_SPEC2,
        IDX_CTRL4, IDX_DIAG1, IDX_DIAG2, 10'h064};

    phyr_regs #(.PHY_ID_LOW(ID_LO), .PHY_ID_HIGH(ID_HI)) u_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_port1_line(port1_line),
        .i_port2_line(port2_line), .i_port2_partner(partner), .o_port2_advertise(o_adv),
        .o_force_link(o_force), .o_eee10_disable(o_eee), .o_near_loopback(o_loop));
    phyr_phy_model u_phy (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_load(st_load), .i_state(st_val),
        .o_port1_line(port1_line), .o_port2_line(port2_line), .o_port2_partner(partner));

    initial begin
        forever #20 i_sys_clk = ~i_sys_clk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [15:0] exp_read(input logic [9:0] idx);
        case (idx)
            IDX_ID_LOW: return ID_LO;
            IDX_ID_HIGH: return ID_HI;
            IDX_ADVERTISE: return {5'h00, pause, r9, ab, SELECTOR_VAL};
            IDX_PARTNER: return {5'h00, st[4], 1'b0, st[3:0], 5'h01};
            IDX_SPEC1: return {10'h000, st[8:7], f[0], e[0], l[0], r0[0]};
            IDX_SPEC2: return {10'h000, st[6:5], f[1], e[1], l[1], r0[1]};
            IDX_CTRL4: return {11'h000, pause, ab};
            IDX_DIAG1: return {4'h0, f[0], 1'b0, l[0], 9'h000};
            IDX_DIAG2: return {4'h0, f[1], 1'b0, l[1], 9'h000};
            default: return 16'h0000;
        endcase
    endfunction

    // Shadow of the shared storage; byte lanes gate each field
    task automatic apply_write(input logic [9:0] idx, input logic [15:0] d, input logic [3:0] bm);
        case (idx)
            IDX_ADVERTISE: begin
                if (bm[1]) {pause, r9, ab[3]} = d[10:8];
                if (bm[0]) ab[2:0] = d[7:5];
            end
            IDX_CTRL4: if (bm[0]) {pause, ab} = d[4:0];
            IDX_SPEC1: if (bm[0]) {f[0], e[0], l[0], r0[0]} = d[3:0];
            IDX_SPEC2: if (bm[0]) {f[1], e[1], l[1], r0[1]} = d[3:0];
            IDX_DIAG1: if (bm[1]) {f[0], l[0]} = {d[11], d[9]};
            IDX_DIAG2: if (bm[1]) {f[1], l[1]} = {d[11], d[9]};
            default: ;
        endcase
    endtask

    task automatic final_report();
        $display("Counts: %0d comparisons, %0d mismatches", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Request held until waitrequest is sampled low; read data taken at that edge
    task automatic bus_access(input logic is_wr, input logic [9:0] idx, input logic [15:0] d,
                              input logic [3:0] bm);
        int n;
        seed = lfsr_next(seed);
        @(posedge i_sys_clk);
        addr <= {idx, seed[1:0]};
        wdata <= {seed[31:16], d};
        be <= bm;
        wr <= is_wr;
        rd <= !is_wr;
        for (n = 0; n < 20; n++) begin
            @(posedge i_sys_clk);
            if (waitreq === 1'b0) break;
        end
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        if (n == 20) begin
            miscompares++;
            $display("Error waitrequest expected 0 seen 1");
            final_report();
        end else if (is_wr) begin
            apply_write(idx, d, bm);
        end
    endtask

    task automatic check_read(input logic [9:0] idx);
        bus_access(1'b0, idx, 16'h0000, 4'hF);
        `CHECK("readdata", {16'h0000, exp_read(idx)}, q)
    endtask

    task automatic check_all(input string name);
        for (int i = 0; i < 10; i++) check_read(idx_tab[i]);
        `CHECK("advertise out", {pause, ab}, o_adv)
        `CHECK("force link out", f, o_force)
        `CHECK("eee disable out", e, o_eee)
        `CHECK("loopback out", l, o_loop)
        $display("Test %s done, %0d mismatches so far", name, miscompares);
    endtask

    task automatic do_reset();
        @(posedge i_sys_clk);
        i_rst_n <= 1'b0;
        repeat (8) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        {pause, r9, ab, f, e, l, r0, st} = {1'b1, 1'b0, 4'hF, 2'b00, 2'b11, 2'b00, 2'b00, 9'h000};
    endtask

    task automatic load_status(input logic [8:0] v);
        @(posedge i_sys_clk);
        st_load <= 1'b1;
        st_val <= v;
        @(posedge i_sys_clk);
        st_load <= 1'b0;
        st = v;
    endtask

    initial begin
        do_reset();
        check_all("reset values");
        // Every register and alias written with all ones, then with zeros
        for (int i = 0; i < 10; i++) bus_access(1'b1, idx_tab[i], 16'hFFFF, 4'hF);
        load_status(9'h1FF);
        check_all("all ones");
        for (int i = 0; i < 10; i++) bus_access(1'b1, idx_tab[i], 16'h0000, 4'hF);
        check_all("all zeros");
        for (int k = 0; k < 400; k++) begin
            seed = lfsr_next(seed);
            if (seed[3:0] == 4'h0) begin
                load_status(seed[20:12]);
            end else begin
                bus_access(1'b1, idx_tab[seed[7:4] % 10], seed[31:16], seed[11:8]);
                check_read(idx_tab[seed[27:24] % 10]);
            end
        end
        check_all("random traffic");
        do_reset();
        check_all("second reset");
        final_report();
    end
endmodule
